// file: jpc_pkg.sv
// jpc_pkg: shared constants of the scan programming command engine
// assumes: included first; both link ends import it
package jpc_pkg;
  // ------------------------------------------------------------------
  // scan register widths and layout
  // ------------------------------------------------------------------
  localparam int EN_W = 16;                   // enable register width
  localparam int CMD_W = 15;                  // command register width
  localparam int OP_W = 7;                    // opcode field width
  localparam int OPND_W = 8;                  // operand field width
  localparam int FLAG_BIT = 9;                // completion flag position
  localparam logic [15:0] UNLOCK_SIG = 16'hA370; // unlock signature
  localparam logic [15:0] EN_RST = 16'h0000;  // enable register reset
  // ------------------------------------------------------------------
  // opcodes (upper seven bits of a command word)
  // ------------------------------------------------------------------
  localparam logic [6:0] OP_ENTER = 7'h23;    // select mode from operand
  localparam logic [6:0] OP_AEXT = 7'h0B;     // extended high address
  localparam logic [6:0] OP_AHI = 7'h07;      // high address byte
  localparam logic [6:0] OP_ALO = 7'h03;      // low address byte
  localparam logic [6:0] OP_DLO = 7'h13;      // data low byte
  localparam logic [6:0] OP_DHI = 7'h17;      // data high byte
  localparam logic [6:0] OP_LATCH = 7'h77;    // latch into page buffer
  localparam logic [6:0] OP_CMT_H = 7'h35;    // commit flash / high fuse
  localparam logic [6:0] OP_CMT_L = 7'h31;    // commit erase/eeprom/low/lock
  localparam logic [6:0] OP_CMT_E = 7'h39;    // commit extended fuse
  localparam logic [6:0] OP_IDLE_H = 7'h37;   // poll, flash high read
  localparam logic [6:0] OP_IDLE_L = 7'h33;   // poll, eeprom read
  localparam logic [6:0] OP_RD_LO = 7'h36;    // flash low byte read
  localparam logic [6:0] OP_RD_FE = 7'h3B;    // extended fuse read
  localparam logic [6:0] OP_PRE_RD = 7'h32;   // read preparation word
  localparam logic [6:0] OP_PRE_FE = 7'h3A;   // fuse read preparation
  // ------------------------------------------------------------------
  // modes carried by the operand of OP_ENTER
  // ------------------------------------------------------------------
  localparam logic [7:0] MODE_ERASE = 8'h80;
  localparam logic [7:0] MODE_FL_WR = 8'h10;
  localparam logic [7:0] MODE_FL_RD = 8'h02;
  localparam logic [7:0] MODE_EE_WR = 8'h11;
  localparam logic [7:0] MODE_EE_RD = 8'h03;
  localparam logic [7:0] MODE_FU_WR = 8'h40;
  localparam logic [7:0] MODE_LK_WR = 8'h20;
  localparam logic [7:0] MODE_FU_RD = 8'h04;
  localparam logic [7:0] MODE_NONE = 8'h00;
  localparam logic [7:0] LOCK_KEEP = 8'hC0;   // top bits that must be one
  localparam logic [7:0] ERASED = 8'hFF;      // erased / unprogrammed byte
  // ------------------------------------------------------------------
  // timing
  // ------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 5;           // host clock period
  localparam int TCK_PERIOD_NS = 80;          // link clock period
  localparam int TCK_HALF = TCK_PERIOD_NS / (2 * CLK_PERIOD_NS);
  localparam int WRITE_TCK = 64;              // busy time of a commit
  // ------------------------------------------------------------------
  // host frame states, gray along capture-shift-update
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    HS_IDLE = 2'h0,
    HS_CAPT = 2'h1,
    HS_SHIFT = 2'h3,
    HS_UPD = 2'h2
  } jpc_hstate_t;
endpackage : jpc_pkg

// file: jpc_link_if.sv
// jpc_link_if: scan link between programmer (host) and device
// assumes: host makes tck; device logic runs on tck; wire levels only
`timescale 1ns/100ps
`default_nettype none
interface jpc_link_if;
  logic tck;      // link clock, made by the host
  logic sel;      // 0 enable register, 1 command register
  logic capture;  // capture phase of a frame
  logic shift;    // shift phase, one bit per tck
  logic update;   // update phase, applies shifted word
  logic tdi;      // serial data to device, lsb first
  logic tdo;      // serial data from device, lsb first
  modport host (output tck, output sel, output capture, output shift,
                output update, output tdi, input tdo);
  modport dev (input tck, input sel, input capture, input shift,
               input update, input tdi, output tdo);
endinterface : jpc_link_if
`default_nettype wire

// file: jpc_sync2.sv
// jpc_sync2: two flip-flop synchroniser for one level
// assumes: din is asynchronous to clk; only the second stage is read
`timescale 1ns/100ps
`default_nettype none
module jpc_sync2 (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // level in and out
  input wire logic din,
  output logic dout
);
  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  typedef struct packed {
    logic meta;   // first stage, read by the second stage only
    logic sync;   // second stage
  } jpc_sync_t;
  jpc_sync_t s_r, s_nxt;

  // next state: plain two stage pipe
  always_comb begin
    s_nxt.meta = din;
    s_nxt.sync = s_r.meta;
    if (!nrst) begin
      s_nxt = '0;
    end
  end

  // register
  always_ff @(posedge clk) begin
    s_r <= s_nxt;
  end

  assign dout = s_r.sync;
endmodule : jpc_sync2
`default_nettype wire

// file: jpc_dev.sv
// jpc_dev: device end, enable and command scan registers plus the
// small nonvolatile model (flash, eeprom, fuses, lock) they program.
// assumes: all logic runs on the link clock; nrst may come from any
// domain, passes two tck flops, and is held low for at least four
// tck edges while tck runs; the host keeps controls stable
// around each rising tck edge.
`timescale 1ns/100ps
`default_nettype none
module jpc_dev
  import jpc_pkg::*;
#(
  parameter int FLASH_AW = 6,          // flash word address width
  parameter int PAGE_AW = 2,           // words per flash page, log2
  parameter int EE_AW = 5,             // eeprom byte address width
  parameter int EPAGE_AW = 2,          // bytes per eeprom page, log2
  parameter int WRITE_CYCLES = WRITE_TCK, // tck cycles of a commit
  parameter logic [7:0] FUSE_E_INIT = ERASED, // arbitrary start value
  parameter logic [7:0] FUSE_H_INIT = ERASED, // arbitrary start value
  parameter logic [7:0] FUSE_L_INIT = ERASED  // arbitrary start value
) (
  // reset from any domain, synchronised to the link clock inside
  input wire logic nrst,
  // link
  jpc_link_if.dev link,
  // device status
  output logic prog_mode,
  output logic busy,
  // nonvolatile bytes as seen by the rest of the chip
  output logic [7:0] fuse_ext,
  output logic [7:0] fuse_high,
  output logic [7:0] fuse_low,
  output logic [7:0] lock_bits
);
  localparam int FLASH_N = 1 << FLASH_AW;
  localparam int PAGE_N = 1 << PAGE_AW;
  localparam int EE_N = 1 << EE_AW;
  localparam int EPAGE_N = 1 << EPAGE_AW;

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [EN_W-1:0] en_sh;            // enable shift stage
    logic [EN_W-1:0] en;               // enable register proper
    logic [CMD_W-1:0] cmd_sh;          // command shift register
    logic [CMD_W-1:0] result;          // result of last command
    logic [7:0] mode;                  // mode picked by OP_ENTER
    logic [6:0] a_ext;                 // extended address
    logic [7:0] a_hi;                  // high address
    logic [7:0] a_lo;                  // low address
    logic [7:0] d_lo;                  // data low byte
    logic [7:0] d_hi;                  // data high byte
    logic [PAGE_N-1:0][15:0] pbuf;     // flash page buffer
    logic [EPAGE_N-1:0][7:0] epbuf;    // eeprom page buffer
    logic [FLASH_N-1:0][15:0] flash;   // flash words
    logic [EE_N-1:0][7:0] ee;          // eeprom bytes
    logic [7:0] fuse_e;
    logic [7:0] fuse_h;
    logic [7:0] fuse_l;
    logic [7:0] lock;
    logic [15:0] busy_cnt;             // remaining commit cycles
    logic tdo;                         // serial out, registered
    logic prog;                        // registered signature match
    logic busy;                        // registered busy
  } jpc_dev_t;
  jpc_dev_t s_r, s_nxt;

  // ------------------------------------------------------------------
  // decode helpers
  // ------------------------------------------------------------------
  // poll words of every write mode share these two opcodes
  function automatic logic is_idle_op(input logic [6:0] op);
    is_idle_op = (op == OP_IDLE_H) || (op == OP_IDLE_L);
  endfunction : is_idle_op

  // a commit pulse is only honoured in a write or erase mode
  function automatic logic is_wr_mode(input logic [7:0] m);
    is_wr_mode = (m == MODE_ERASE) || (m == MODE_FL_WR) || (m == MODE_EE_WR)
      || (m == MODE_FU_WR) || (m == MODE_LK_WR);
  endfunction : is_wr_mode

  logic [6:0] op;                      // opcode being applied
  logic [7:0] opnd;                    // operand being applied
  logic [FLASH_AW-1:0] faddr;          // flash word address
  logic [EE_AW-1:0] eaddr;             // eeprom byte address
  logic commit;                        // commit pulse accepted
  int fbase;                           // first word of the flash page
  int ebase;                           // first byte of the eeprom page
  logic nrst_s;                        // reset after two tck flops

  // reset comes from the host clock domain; two tck flops keep it
  // from racing the tck edge that samples it
  jpc_sync2 u_rst_sync (
    .clk(link.tck),
    .nrst(1'b1),
    .din(nrst),
    .dout(nrst_s)
  );

  assign op = s_r.cmd_sh[CMD_W-1 -: OP_W];
  assign opnd = s_r.cmd_sh[OPND_W-1:0];
  assign faddr = FLASH_AW'({s_r.a_ext, s_r.a_hi, s_r.a_lo});
  assign eaddr = EE_AW'({s_r.a_hi, s_r.a_lo});

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    commit = 1'b0;
    fbase = int'(faddr) & ~(PAGE_N - 1);
    ebase = int'(eaddr) & ~(EPAGE_N - 1);
    // commit timer runs down on its own
    if (s_r.busy_cnt != 16'h0000) begin
      s_nxt.busy_cnt = s_r.busy_cnt - 16'h0001;
    end
    // capture: previous result goes out in this frame
    if (link.capture && link.sel) begin
      s_nxt.cmd_sh = s_r.result;
    end
    // shift: lsb leaves first, new bit enters at the top
    if (link.shift) begin
      if (link.sel) begin
        s_nxt.cmd_sh = {link.tdi, s_r.cmd_sh[CMD_W-1:1]};
      end else begin
        s_nxt.en_sh = {link.tdi, s_r.en_sh[EN_W-1:1]};
      end
    end
    // update of the enable register
    if (link.update && !link.sel) begin
      s_nxt.en = s_r.en_sh;
    end
    // update of the command register executes the word, only while prog is set
    if (link.update && link.sel && s_r.prog) begin
      s_nxt.result = '0;
      case (op)
        OP_ENTER: begin
          s_nxt.mode = opnd;
        end
        OP_AEXT: begin
          s_nxt.a_ext = opnd[6:0];
        end
        OP_AHI: begin
          s_nxt.a_hi = opnd;
        end
        OP_ALO: begin
          s_nxt.a_lo = opnd;
        end
        OP_DLO: begin
          s_nxt.d_lo = opnd;
        end
        OP_DHI: begin
          s_nxt.d_hi = opnd;
        end
        OP_LATCH: begin
          // top bit pulsed high: word into the page buffer
          if (s_r.mode == MODE_FL_WR) begin
            s_nxt.pbuf[s_r.a_lo[PAGE_AW-1:0]] = {s_r.d_hi, s_r.d_lo};
          end else if (s_r.mode == MODE_EE_WR) begin
            s_nxt.epbuf[s_r.a_lo[EPAGE_AW-1:0]] = s_r.d_lo;
          end
        end
        OP_CMT_H, OP_CMT_L, OP_CMT_E: begin
          // a second commit while busy is dropped, not queued
          commit = is_wr_mode(s_r.mode) && (s_r.busy_cnt == 16'h0000);
        end
        OP_RD_LO: begin
          if (s_r.mode == MODE_FL_RD) begin
            s_nxt.result[7:0] = s_r.flash[faddr][7:0];
          end
        end
        OP_RD_FE: begin
          if (s_r.mode == MODE_FU_RD) begin
            s_nxt.result[7:0] = s_r.fuse_e;
          end
        end
        default: begin
          // preparation and unknown words only clear the result
        end
      endcase
      // memory effects of an accepted commit pulse
      if (commit) begin
        s_nxt.busy_cnt = 16'(WRITE_CYCLES);
        if (s_r.mode == MODE_ERASE && op == OP_CMT_L) begin
          s_nxt.flash = '1;
          s_nxt.ee = '1;
          s_nxt.lock = ERASED;
        end else if (s_r.mode == MODE_FL_WR && op == OP_CMT_H) begin
          for (int i = 0; i < PAGE_N; i++) begin
            s_nxt.flash[fbase + i] = s_r.pbuf[i];
          end
        end else if (s_r.mode == MODE_EE_WR && op == OP_CMT_L) begin
          for (int i = 0; i < EPAGE_N; i++) begin
            s_nxt.ee[ebase + i] = s_r.epbuf[i];
          end
        end else if (s_r.mode == MODE_FU_WR && op == OP_CMT_E) begin
          s_nxt.fuse_e = s_r.d_lo;
        end else if (s_r.mode == MODE_FU_WR && op == OP_CMT_H) begin
          s_nxt.fuse_h = s_r.d_lo;
        end else if (s_r.mode == MODE_FU_WR && op == OP_CMT_L) begin
          s_nxt.fuse_l = s_r.d_lo;
        end else if (s_r.mode == MODE_LK_WR && op == OP_CMT_L) begin
          // a byte without both top bits set is not stored
          if ((s_r.d_lo & LOCK_KEEP) == LOCK_KEEP) begin
            s_nxt.lock = s_r.d_lo;
          end
        end else begin
          s_nxt.busy_cnt = 16'h0000;
        end
      end
      // idle words: read data in flash/eeprom read modes, completion flag in write modes
      if (is_idle_op(op)) begin
        if (s_r.mode == MODE_FL_RD && op == OP_IDLE_H) begin
          s_nxt.result[7:0] = s_r.flash[faddr][15:8];
        end else if (s_r.mode == MODE_EE_RD && op == OP_IDLE_L) begin
          s_nxt.result[7:0] = s_r.ee[eaddr];
        end else if (is_wr_mode(s_r.mode)) begin
          // flag set means done; reflects the timer at this update
          s_nxt.result[FLAG_BIT] = (s_nxt.busy_cnt == 16'h0000);
        end
      end
    end
    // serial output follows the selected register's lsb
    s_nxt.tdo = link.sel ? s_nxt.cmd_sh[0] : s_nxt.en_sh[0];
    s_nxt.prog = (s_nxt.en == UNLOCK_SIG);
    s_nxt.busy = (s_nxt.busy_cnt != 16'h0000);
    // reset: enable cleared, nonvolatile model back to its start
    if (!nrst_s) begin
      s_nxt = '0;
      s_nxt.en = EN_RST;
      s_nxt.mode = MODE_NONE;
      s_nxt.flash = '1;
      s_nxt.ee = '1;
      s_nxt.fuse_e = FUSE_E_INIT;
      s_nxt.fuse_h = FUSE_H_INIT;
      s_nxt.fuse_l = FUSE_L_INIT;
      s_nxt.lock = ERASED;
    end
  end

  // register, all on the link clock
  always_ff @(posedge link.tck) begin
    s_r <= s_nxt;
  end

  // ------------------------------------------------------------------
  // outputs, each straight from a flop
  // ------------------------------------------------------------------
  assign link.tdo = s_r.tdo;
  assign prog_mode = s_r.prog;
  assign busy = s_r.busy;
  assign fuse_ext = s_r.fuse_e;
  assign fuse_high = s_r.fuse_h;
  assign fuse_low = s_r.fuse_l;
  assign lock_bits = s_r.lock;
endmodule : jpc_dev
`default_nettype wire

// file: jpc_host.sv
// jpc_host: programmer end; runs one scan frame per request
// (capture, shift, update) and returns the word shifted out.
// assumes: clk/nrst local; tck is made here by dividing clk; tdo is
// a pin and is synchronised before use.
`timescale 1ns/100ps
`default_nettype none
module jpc_host
  import jpc_pkg::*;
#(
  parameter int HALF = TCK_HALF        // clk cycles per tck half period
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // request
  input wire logic req_valid,
  input wire logic req_sel,            // 0 enable reg, 1 command reg
  input wire logic [15:0] req_word,
  output logic req_ready,
  // answer
  output logic rsp_valid,
  output logic [CMD_W-1:0] rsp_word,
  // link
  jpc_link_if.host link
);
  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  typedef struct packed {
    jpc_hstate_t st;
    logic [7:0] half_cnt;              // position inside a half period
    logic tck;
    logic sel;
    logic nsel;                        // select held until capture
    logic capture;
    logic shift;
    logic update;
    logic tdi;
    logic [15:0] word;                 // word to shift out
    logic [4:0] idx;                   // current bit index
    logic [CMD_W-1:0] rsp;             // bits gathered from tdo
    logic rsp_valid;
    logic req_ready;
  } jpc_host_t;
  jpc_host_t s_r, s_nxt;

  logic tdo_s;                         // synchronised tdo
  logic edge_now;                      // tck toggles this cycle
  logic [4:0] last;                    // index of the last bit

  jpc_sync2 u_tdo_sync (
    .clk(clk),
    .nrst(nrst),
    .din(link.tdo),
    .dout(tdo_s)
  );

  assign edge_now = (s_r.half_cnt == 8'(HALF - 1));
  assign last = s_r.sel ? 5'(CMD_W - 1) : 5'(EN_W - 1);

  // ------------------------------------------------------------------
  // next state: controls only move on the falling tck edge, so they
  // are a full half period stable before the device samples them
  // ------------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    s_nxt.rsp_valid = 1'b0;
    s_nxt.half_cnt = edge_now ? 8'h00 : s_r.half_cnt + 8'h01;
    if (edge_now) begin
      s_nxt.tck = !s_r.tck;
    end
    // sample tdo just before the rise that shifts it away
    if (edge_now && !s_r.tck && s_r.shift && s_r.idx < 5'(CMD_W)) begin
      s_nxt.rsp[s_r.idx[3:0]] = tdo_s;
    end
    case (s_r.st)
      HS_IDLE: begin
        if (req_valid && s_r.req_ready) begin
          // enable frames carry the signature in, or zero to leave
          s_nxt.word = req_word;
          s_nxt.nsel = req_sel;
          s_nxt.req_ready = 1'b0;
        end else if (edge_now && s_r.tck && !s_r.req_ready) begin
          // select moves on a falling edge only, never beside a rise
          s_nxt.sel = s_r.nsel;
          s_nxt.capture = 1'b1;
          s_nxt.st = HS_CAPT;
        end
      end
      HS_CAPT: begin
        if (edge_now && s_r.tck) begin
          s_nxt.capture = 1'b0;
          s_nxt.shift = 1'b1;
          s_nxt.idx = 5'h00;
          s_nxt.tdi = s_r.word[0];
          s_nxt.st = HS_SHIFT;
        end
      end
      HS_SHIFT: begin
        if (edge_now && s_r.tck) begin
          if (s_r.idx == last) begin
            s_nxt.shift = 1'b0;
            s_nxt.update = 1'b1;
            s_nxt.st = HS_UPD;
          end else begin
            s_nxt.idx = s_r.idx + 5'h01;
            s_nxt.tdi = s_r.word[s_r.idx[3:0] + 4'h1];
          end
        end
      end
      HS_UPD: begin
        if (edge_now && s_r.tck) begin
          // word is applied; command words may be sent in any order,
          // skipping preparation words is the requester's choice
          s_nxt.update = 1'b0;
          s_nxt.rsp_valid = 1'b1;
          s_nxt.req_ready = 1'b1;
          s_nxt.st = HS_IDLE;
        end
      end
      default: begin
        s_nxt.st = HS_IDLE;
      end
    endcase
    if (!nrst) begin
      s_nxt = '0;
      s_nxt.st = HS_IDLE;
      s_nxt.req_ready = 1'b1;
    end
  end

  // register
  always_ff @(posedge clk) begin
    s_r <= s_nxt;
  end

  // ------------------------------------------------------------------
  // outputs, each straight from a flop
  // ------------------------------------------------------------------
  assign req_ready = s_r.req_ready;
  assign rsp_valid = s_r.rsp_valid;
  assign rsp_word = s_r.rsp;
  assign link.tck = s_r.tck;
  assign link.sel = s_r.sel;
  assign link.capture = s_r.capture;
  assign link.shift = s_r.shift;
  assign link.update = s_r.update;
  assign link.tdi = s_r.tdi;
endmodule : jpc_host
`default_nettype wire

// file: jpc_checker.sv
// jpc_checker: frame timing of the scan link between the two ends
// assumes: fed with the link wires and both resets by the testbench
`timescale 1ns/100ps
`default_nettype none
module jpc_checker (
  // host clock and reset
  input wire logic clk,
  input wire logic nrst,
  // link reset and wires
  input wire logic link_nrst,
  input wire logic tck,
  input wire logic sel,
  input wire logic capture,
  input wire logic shift,
  input wire logic update,
  input wire logic tdi,
  input wire logic tdo
);
  // --------------------------------------------------------------
  // shift edges seen since capture, so the frame width is exact
  // --------------------------------------------------------------
  logic [4:0] nbits_r;
  logic [4:0] nbits_nxt;
  always_comb nbits_nxt = capture ? 5'h00 : nbits_r + {4'h0, shift};
  always_ff @(posedge tck) nbits_r <= link_nrst ? nbits_nxt : 5'h00;
  // --------------------------------------------------------------
  // link domain, sampled where the device samples
  // --------------------------------------------------------------
  a_frame_width: assert property (@(posedge tck) disable iff (!link_nrst)
    update |-> nbits_r == (sel ? 5'h0F : 5'h10)) else $error("frame width wrong");
  a_capt_shift: assert property (@(posedge tck) disable iff (!link_nrst)
    capture |=> shift && !capture) else $error("no shift after capture");
  a_shift_upd: assert property (@(posedge tck) disable iff (!link_nrst)
    $fell(shift) |-> update && !capture) else $error("no update after shift");
  a_shift_run: assert property (@(posedge tck) disable iff (!link_nrst)
    $rose(shift) |-> shift[*8]) else $error("shift phase too short");
  a_upd_single: assert property (@(posedge tck) disable iff (!link_nrst)
    update |=> !update && !shift) else $error("update held too long");
  a_sel_steady: assert property (@(posedge tck) disable iff (!link_nrst)
    shift |-> $stable(sel)) else $error("select moved in frame");
  // --------------------------------------------------------------
  // host domain: data lines move only on their own tck edge
  // --------------------------------------------------------------
  a_tdo_rise: assert property (@(posedge clk) disable iff (!nrst)
    !$rose(tck) |-> $stable(tdo)) else $error("tdo moved off rising tck");
  a_tdi_fall: assert property (@(posedge clk) disable iff (!nrst)
    !$fell(tck) |-> $stable(tdi)) else $error("tdi moved off falling tck");
endmodule : jpc_checker
`default_nettype wire

// file: tb.sv
// tb: programmer end runs a table of frames against the device end
// assumes: host leaves reset first so tck runs while the device resets
`timescale 1ns/100ps
`default_nettype none
module tb;
  // stimulus, status and bookkeeping
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic link_nrst = 1'b0;
  logic req_valid = 1'b0;
  logic req_sel = 1'b0;
  logic [15:0] req_word = 16'h0000;
  logic req_ready, rsp_valid, prog_mode;
  logic [14:0] rsp_word;
  logic [7:0] fe, fh, fl, lk;
  logic bz;
  logic [7:0] r [8]; // random operands, r[0] stays zero
  logic [29:0] q [$]; // notes: {mask, masked value}
  int failures = 0;
  int total_checks = 0;
  // {expect: F flag, n byte r[n]; operand r[n], 8 = enable frame; word}
  logic [23:0] seq [$] = '{24'h08_A370, 24'h00_2380, 24'h00_3180, 24'h00_3380, 24'h00_3380,
    24'hF0_2310, 24'h00_0B00, 24'h00_0700, 24'h01_0300, 24'h02_1300, 24'h03_1700,
    24'h00_3700, 24'h00_7700, 24'h00_3700, 24'h00_3700, 24'h00_3500, 24'h00_3700,
    24'h00_3700, 24'h00_3700, 24'hF0_2302, 24'h00_0700, 24'h01_0300, 24'h00_3200,
    24'h00_3600, 24'h20_3700, 24'h30_2311, 24'h00_0700, 24'h01_0300, 24'h04_1300,
    24'h00_3700, 24'h00_7700, 24'h00_3700, 24'h00_3300, 24'h00_3100, 24'h00_3300,
    24'h00_3300, 24'h00_3300, 24'hF0_2303, 24'h00_0700, 24'h01_0300, 24'h01_3300,
    24'h00_3200, 24'h00_3300, 24'h40_2340, 24'h05_1300, 24'h00_3B00, 24'h00_3900,
    24'h00_3B00, 24'h00_3B00, 24'h00_3700,
    24'h00_3500, 24'h00_3700, 24'h00_3100, 24'h00_3300, // no preparation words
    24'hF0_2304, 24'h00_3A00, 24'h00_3B00,
    24'h50_2320, 24'h06_1300, 24'h00_3300, 24'h00_3100, 24'h00_3300, 24'h00_3300,
    24'h00_3300, 24'hF7_1300, 24'h00_3300, 24'h00_3100, 24'h00_3300, 24'h00_3300,
    24'h08_0000, 24'h00_2340, 24'h00_1300, 24'h00_3900, 24'h00_3B00};
  always #2.5 clk = ~clk;
  // both ends face each other; tck is the host's divided clock
  jpc_link_if link ();
  jpc_host #(.HALF(8)) jpc_host_inst (.clk(clk), .nrst(nrst), .req_valid(req_valid),
    .req_sel(req_sel), .req_word(req_word), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp_word(rsp_word), .link(link));
  jpc_dev #(.WRITE_CYCLES(4)) jpc_dev_inst (.nrst(link_nrst), .link(link),
    .prog_mode(prog_mode), .busy(bz), .fuse_ext(fe), .fuse_high(fh), .fuse_low(fl),
    .lock_bits(lk));
  jpc_checker jpc_checker_inst (.clk(clk), .nrst(nrst), .link_nrst(link_nrst),
    .tck(link.tck), .sel(link.sel), .capture(link.capture), .shift(link.shift),
    .update(link.update), .tdi(link.tdi), .tdo(link.tdo));
  task automatic chk(input string nm, input logic [14:0] e, input logic [14:0] s);
    total_checks++;
    if (s !== e) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic conclude;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : conclude
  // one frame; valid is held until the host is seen ready at an edge
  task automatic fr(input logic s, input logic [15:0] w, input logic [29:0] ex);
    q.push_back(ex);
    req_sel <= s;
    req_word <= w;
    req_valid <= 1'b1;
    do @(posedge clk); while (req_ready !== 1'b1);
    req_valid <= 1'b0;
    @(posedge clk);
  endtask : fr
  // each command-frame answer carries the previous command's result
  always @(posedge clk) begin
    if (rsp_valid === 1'b1 && q.size() > 0) begin
      chk("rsp_word", q[0][14:0], rsp_word & q[0][29:15]);
      void'(q.pop_front());
    end
  end
  initial begin
    logic [23:0] t;
    void'($urandom(81476));
    foreach (r[i]) r[i] = 8'($urandom);
    r[0] = 8'h00;
    r[1] = r[1] & 8'h3F; // address inside the flash
    r[6] = r[6] | 8'hC0; // lock byte with top bits kept
    r[7] = r[6] & 8'h3F; // same byte without them, must be refused
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    repeat (80) @(posedge clk); // device reset must pass its two tck flops
    link_nrst <= 1'b1;
    repeat (48) @(posedge clk);
    foreach (seq[i]) begin
      t = seq[i];
      fr(!t[19], t[15:0] | {8'h00, r[t[18:16]]}, (t[23:20] == 4'hF) ? {15'h0200, 15'h0200} :
        (t[23:20] == 4'h0) ? '0 : {15'h00FF, 7'h00, r[t[22:20]]});
    end
    while (q.size() > 0) @(posedge clk);
    chk("fuse_ext", {7'h00, r[5]}, {7'h00, fe});
    chk("fuse_high", {7'h00, r[5]}, {7'h00, fh});
    chk("fuse_low", {7'h00, r[5]}, {7'h00, fl});
    chk("busy", 15'h0000, {14'h0000, bz});
    chk("lock_bits", {7'h00, r[6]}, {7'h00, lk});
    chk("prog_mode", 15'h0000, {14'h0000, prog_mode});
    conclude();
  end
  // watchdog, about three times the expected run
  initial begin
    repeat (60000) @(posedge clk);
    failures++;
    conclude();
  end
endmodule : tb
`default_nettype wire
